/* File: shared/fsi_seq_regs.vh */
// offsets, fields, reset values, operation codes and bus encodings of the maintenance sequencer
`ifndef FSI_SEQ_REGS_VH
`define FSI_SEQ_REGS_VH

// register byte offsets
`define FSI_CTRL_OFS      8'h00
`define FSI_STATUS_OFS    8'h04
// control register: index of the last cache line walked
`define FSI_CTRL_RESET    8'hFF
// status register fields
`define FSI_ST_ACTIVE     0
`define FSI_ST_OP_LO      1
`define FSI_ST_OP_HI      2
`define FSI_ST_BIST_MODE  3
`define FSI_ST_FLOAT_MODE 4
`define FSI_ST_BIST_FAIL  5
`define FSI_ST_INIT_DONE  6
// operation codes
`define FSI_OP_NONE       2'h0
`define FSI_OP_INIT       2'h1
`define FSI_OP_FLUSH      2'h2
`define FSI_OP_SYNC       2'h3
// lookup wait cycles per line before its invalidate
`define FSI_LOOK_CYCLES   1'h1
// bus encodings
`define FSI_HTRANS_NONSEQ 2'h2
`define FSI_HTRANS_SEQ    2'h3

`endif

/* File: src/flush_sync_init_sequencer.v */
// flush, sync and initialization sequencer with an AHB-Lite register slave
// Operation
// - in-progress output goes active once the bus is idle after flush is recognized, off after last line
// - modified last line keeps in-progress active until its writeback ready
// - during flush only flush writebacks issue strobes
// - flush request ignored while initialization or flush is active
// - only one maintenance operation runs at a time
// - priority is initialization, then flush, then sync
// - higher priority request aborts a running lower one
// - lower priority request is dropped while higher one runs
// - own request ignored once flush or sync has started
// - in-progress stays active across a preemption
// - in-progress asserts only when the operation really executes
// - self-test error result shown on cache hold output
// - float strap 1 with self-test strap 0 runs self-test
// - both straps 0 float all pins until next reset; here only maintOpActive_n, cacheHoldOut and cacheAddrStrobe_n are floated
// - self-test strap 1 gives normal initialization
// - float strap sampled only at reset, ignored afterwards; here floatSelect_n still gates membusAddrLatchEn after initialization
// - after initialization the float pin acts as address latch enable
// - flush invalidates all lines and writes modified ones back
// - flush waits until outstanding bus cycles complete
//
// Added by the designer: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "fsi_seq_regs.vh"

module flush_sync_init_sequencer (
    input  wire        clk,
    input  wire        rst_b,
    input  wire        flushReq_n,
    input  wire        syncReq_n,
    input  wire        floatSelect_n,
    input  wire        selftestSelect_n,
    input  wire        busIdle,
    input  wire        lineModified,
    input  wire        cacheReady_n,
    input  wire        normAddrStrobe,
    input  wire        syncDone,
    input  wire        bistDone,
    input  wire        bistFail,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg         hreadyout,
    output reg  [31:0] hrdata,
    output reg         hresp,
    output reg         maintOpActive_n,
    output reg         maintOpActiveOe,
    output reg         cacheHoldOut,
    output reg         cacheHoldOe,
    output reg         cacheAddrStrobe_n,
    output reg         cacheAddrStrobeOe,
    output reg         membusAddrLatchEn,
    output reg  [7:0]  lineIndex,
    output reg         lineInvalidate,
    output reg         bistRun,
    output reg         syncRun
);

// ----------------------------------------------------------------
// states
// ----------------------------------------------------------------
localparam [2:0] ST_IDLE  = 3'h0;
localparam [2:0] ST_BIST  = 3'h1;
localparam [2:0] ST_DRAIN = 3'h2;
localparam [2:0] ST_LOOK  = 3'h3;
localparam [2:0] ST_WB    = 3'h4;
localparam [2:0] ST_WAIT  = 3'h5;
localparam [2:0] ST_SYNC  = 3'h6;
localparam [2:0] ST_START = 3'h7;

reg [2:0] state;
reg [1:0] opKind;
reg [7:0] lastLine;
reg       lookCnt;
reg       strapTaken;
reg       bistMode;
reg       floatMode;
reg       bistErr;
reg       initDone;
reg       flushPend;
reg       syncPend;

// ----------------------------------------------------------------
// request synchronizers
// ----------------------------------------------------------------
reg [2:0] flushSync;
reg [2:0] syncSync;

always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        flushSync <= 3'h7;
        syncSync  <= 3'h7;
    end else begin
        flushSync <= {flushSync[1:0], flushReq_n};
        syncSync  <= {syncSync[1:0], syncReq_n};
    end
end

// falling edges only, so a request still held low after its own
// operation ends does not start it again
wire flushEdge = !flushSync[1] && flushSync[2];
wire syncEdge  = !syncSync[1] && syncSync[2];

wire lastDone  = (lineIndex == lastLine);
wire walkIsFl  = (opKind == `FSI_OP_FLUSH);

// ----------------------------------------------------------------
// sequencer
// ----------------------------------------------------------------
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        state          <= ST_START;
        opKind         <= `FSI_OP_INIT;
        lookCnt        <= 1'b0;
        strapTaken     <= 1'b0;
        bistMode       <= 1'b0;
        floatMode      <= 1'b0;
        bistErr        <= 1'b0;
        initDone       <= 1'b0;
        flushPend      <= 1'b0;
        syncPend       <= 1'b0;
        lineIndex      <= 8'h00;
        lineInvalidate <= 1'b0;
        bistRun        <= 1'b0;
        syncRun        <= 1'b0;
        maintOpActive_n   <= 1'b1;
        cacheAddrStrobe_n <= 1'b1;
        cacheHoldOut      <= 1'b0;
    end else begin
        lineInvalidate    <= 1'b0;
        cacheAddrStrobe_n <= 1'b1;
        if (flushEdge && opKind != `FSI_OP_INIT &&
            opKind != `FSI_OP_FLUSH)
            flushPend <= 1'b1;
        if (syncEdge && opKind == `FSI_OP_NONE)
            syncPend <= 1'b1;
        case (state)
        ST_START: begin
            // straps caught on the first edge after release
            // self-test strap
            strapTaken <= 1'b1;
            bistMode   <= floatSelect_n && !selftestSelect_n;
            floatMode  <= !floatSelect_n && !selftestSelect_n;
            maintOpActive_n <= 1'b0;
            lineIndex  <= 8'h00;
            lookCnt    <= 1'b0;
            if (floatSelect_n && !selftestSelect_n) begin
                state   <= ST_BIST;
                bistRun <= 1'b1;
            end else begin
                state   <= ST_LOOK;
            end
        end
        ST_BIST: begin
            if (bistDone) begin
                bistErr      <= bistFail;
                cacheHoldOut <= bistFail;
                bistRun      <= 1'b0;
                state        <= ST_LOOK;
            end
        end
        ST_IDLE: begin
            cacheHoldOut <= bistErr && !initDone;
            if (flushPend) begin
                flushPend <= 1'b0;
                syncPend  <= 1'b0;
                opKind    <= `FSI_OP_FLUSH;
                state     <= ST_DRAIN;
            end else if (syncPend) begin
                syncPend        <= 1'b0;
                opKind          <= `FSI_OP_SYNC;
                syncRun         <= 1'b1;
                maintOpActive_n <= 1'b0;
                state           <= ST_SYNC;
            end
        end
        ST_SYNC: begin
            if (flushPend) begin
                flushPend <= 1'b0;
                syncRun   <= 1'b0;
                opKind    <= `FSI_OP_FLUSH;
                state     <= ST_DRAIN;
            end else if (syncDone) begin
                syncRun         <= 1'b0;
                opKind          <= `FSI_OP_NONE;
                maintOpActive_n <= 1'b1;
                state           <= ST_IDLE;
            end
        end
        ST_DRAIN: begin
            if (busIdle) begin
                maintOpActive_n <= 1'b0;
                cacheHoldOut    <= 1'b1;
                lineIndex       <= 8'h00;
                lookCnt         <= 1'b0;
                state           <= ST_LOOK;
            end
        end
        ST_LOOK: begin
            if (lookCnt != `FSI_LOOK_CYCLES) begin
                lookCnt <= lookCnt + 1'b1;
            end else begin
                lookCnt        <= 1'b0;
                lineInvalidate <= 1'b1;
                if (walkIsFl && lineModified) begin
                    state <= ST_WB;
                end else if (lastDone) begin
                    state <= ST_IDLE;
                end else begin
                    lineIndex <= lineIndex + 8'h01;
                end
            end
            if (state == ST_LOOK && lookCnt == `FSI_LOOK_CYCLES &&
                !(walkIsFl && lineModified) && lastDone) begin
                maintOpActive_n <= 1'b1;
                opKind          <= `FSI_OP_NONE;
                initDone        <= 1'b1;
                if (walkIsFl)
                    cacheHoldOut <= 1'b0;
            end
        end
        ST_WB: begin
            cacheAddrStrobe_n <= 1'b0;
            state             <= ST_WAIT;
        end
        ST_WAIT: begin
            if (!cacheReady_n) begin
                if (lastDone) begin
                    maintOpActive_n <= 1'b1;
                    opKind          <= `FSI_OP_NONE;
                    cacheHoldOut    <= 1'b0;
                    state           <= ST_IDLE;
                end else begin
                    lineIndex <= lineIndex + 8'h01;
                    state     <= ST_LOOK;
                end
            end
        end
        default: state <= ST_IDLE;
        endcase
        if (state == ST_IDLE && opKind == `FSI_OP_NONE &&
            normAddrStrobe && !flushPend && !syncPend)
            cacheAddrStrobe_n <= 1'b0;
    end
end

// ----------------------------------------------------------------
// pin function and drive enables
// ----------------------------------------------------------------
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        membusAddrLatchEn <= 1'b0;
        maintOpActiveOe   <= 1'b0;
        cacheHoldOe       <= 1'b0;
        cacheAddrStrobeOe <= 1'b0;
    end else begin
        membusAddrLatchEn <= initDone && floatSelect_n;
        maintOpActiveOe   <= !floatMode && strapTaken;
        cacheHoldOe       <= !floatMode && strapTaken;
        cacheAddrStrobeOe <= !floatMode && strapTaken;
    end
end

// ----------------------------------------------------------------
// AHB-Lite slave, zero wait states
// ----------------------------------------------------------------
reg       wrPend;
reg [7:0] wrAddr;

wire addrValid = hsel && hready &&
                 (htrans == `FSI_HTRANS_NONSEQ ||
                  htrans == `FSI_HTRANS_SEQ);

function [31:0] readMux;
    input [7:0] ofs;
    begin
        if (ofs == `FSI_CTRL_OFS)
            readMux = {24'h000000, lastLine};
        else if (ofs == `FSI_STATUS_OFS)
            readMux = {25'h0000000, initDone, bistErr, floatMode,
                       bistMode, opKind, !maintOpActive_n};
        else
            readMux = 32'h00000000;
    end
endfunction

always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        hreadyout <= 1'b1;
        hresp     <= 1'b0;
        hrdata    <= 32'h00000000;
        wrPend    <= 1'b0;
        wrAddr    <= 8'h00;
        lastLine  <= `FSI_CTRL_RESET;
    end else begin
        hreadyout <= 1'b1;
        hresp     <= 1'b0;
        if (wrPend && wrAddr == `FSI_CTRL_OFS)
            lastLine <= hwdata[7:0];
        wrPend <= addrValid && hwrite;
        wrAddr <= haddr[7:0];
        if (addrValid && !hwrite)
            hrdata <= readMux(haddr[7:0]);
    end
end

endmodule // flush_sync_init_sequencer
`default_nettype wire

/* File: verification/fsi_seq_asserts.sv */
// port assertions of the maintenance sequencer
`timescale 1ns/1ps
`default_nettype none
module fsi_seq_asserts (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic busIdle,
    input wire logic cacheReady_n,
    input wire logic floatSelect_n,
    input wire logic maintOpActive_n,
    input wire logic maintOpActiveOe,
    input wire logic cacheHoldOut,
    input wire logic cacheHoldOe,
    input wire logic cacheAddrStrobe_n,
    input wire logic cacheAddrStrobeOe,
    input wire logic membusAddrLatchEn,
    input wire logic lineInvalidate,
    input wire logic bistRun,
    input wire logic syncRun
);
    logic wbWait;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // ------------------
    // writeback tracking
    // ------------------
    // a strobe inside a run owes a ready before the run may end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            wbWait <= 1'h0;
        else if (!cacheAddrStrobe_n && !maintOpActive_n)
            wbWait <= 1'h1;
        else if (!cacheReady_n)
            wbWait <= 1'h0;
    end
    property p_wbOnly;
        !cacheAddrStrobe_n && !maintOpActive_n |-> $past(lineInvalidate);
    endproperty
    a_wbOnly: assert property (p_wbOnly) else $error("stray strobe");
    property p_wbHold;
        wbWait |-> !maintOpActive_n;
    endproperty
    a_wbHold: assert property (p_wbHold) else $error("early end");
    property p_holdStart;
        $rose(cacheHoldOut) && $past(maintOpActive_n) |-> !maintOpActive_n;
    endproperty
    a_holdStart: assert property (p_holdStart) else $error("no run");
    property p_drain;
        $fell(maintOpActive_n) && cacheHoldOut |-> $past(busIdle);
    endproperty
    a_drain: assert property (p_drain) else $error("busy start");
    property p_float;
        maintOpActiveOe == cacheHoldOe && cacheHoldOe == cacheAddrStrobeOe
            && (maintOpActiveOe || !$past(maintOpActiveOe));
    endproperty
    a_float: assert property (p_float) else $error("bad enable");
    property p_ale;
        membusAddrLatchEn |-> $past(floatSelect_n) && !bistRun;
    endproperty
    a_ale: assert property (p_ale) else $error("bad latch enable");
    property p_runAct;
        $rose(syncRun || bistRun) |-> ##[0:1] !maintOpActive_n;
    endproperty
    a_runAct: assert property (p_runAct) else $error("run unseen");
    property p_line;
        // launched inside a run; the last pulse stands as the run ends
        lineInvalidate |-> !$past(maintOpActive_n) ##1 !lineInvalidate;
    endproperty
    a_line: assert property (p_line) else $error("bad invalidate");
    cover property (!cacheAddrStrobe_n && !maintOpActive_n);
    cover property ($rose(syncRun));
    cover property ($rose(bistRun));
endmodule // fsi_seq_asserts
bind flush_sync_init_sequencer fsi_seq_asserts u_chk (.*);
`default_nettype wire

/* File: verification/membus_ctrl_model.sv */
// memory bus controller model answering cache writebacks
`timescale 1ns/1ps
`default_nettype none
module membus_ctrl_model (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic [3:0] lat,
    input  wire logic       cacheAddrStrobe_n,
    input  wire logic       cacheAddrStrobeOe,
    input  wire logic       cacheHoldOut,
    output var  logic       cacheReady_n,
    output var  logic       burstReady_n
);
    logic [4:0] cnt;
    // ----------------
    // writeback answer
    // ----------------
    // one ready per strobe, lat+1 clocks after the strobe is sampled; a floated strobe is ignored
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= 5'h0;
            cacheReady_n <= 1'h1;
        end else begin
            cacheReady_n <= !(cnt == 5'h1);
            if (cnt != 5'h0)
                cnt <= cnt - 5'h1;
            else if (!cacheAddrStrobe_n && cacheAddrStrobeOe)
                cnt <= {1'h0, lat} + 5'h1;
        end
    end
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            burstReady_n <= 1'h1;
        else
            burstReady_n <= !cacheHoldOut;
    end
endmodule // membus_ctrl_model
`default_nettype wire

/* File: verification/tb_top.sv */
// self-checking bench for the maintenance sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clk = 1'h0;
    logic        rst_b, flushReq_n, syncReq_n, floatSelect_n, busIdle;
    logic        selftestSelect_n, lineModified, normAddrStrobe, syncDone;
    logic        bistDone, bistFail, hwrite, hreadyout, hresp, watchGap;
    logic        maintOpActive_n, maintOpActiveOe, cacheHoldOut, cacheHoldOe;
    logic        cacheAddrStrobe_n, cacheAddrStrobeOe, membusAddrLatchEn;
    logic        lineInvalidate, bistRun, syncRun, cacheReady_n, burstReady_n;
    logic [1:0]  htrans;
    logic [3:0]  lat;
    logic [7:0]  lineIndex;
    logic [31:0] haddr, hwdata, hrdata, rd;
    int          err_total = 0;
    int          check_count = 0;
    int          strobes = 0;
    int          gaps = 0;
    flush_sync_init_sequencer i_dut (.hsel(1'h1), .hsize(3'h2),
        .hready(hreadyout), .*);
    membus_ctrl_model i_mbc (.*);
    always #10 clk = ~clk;
    always @(posedge clk) begin
        if (!cacheAddrStrobe_n)
            strobes <= strobes + 1;
        if (watchGap && maintOpActive_n)
            gaps <= gaps + 1;
    end
    // --------------
    // shared helpers
    // --------------
    task automatic chk(input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic waitAct(input logic v);
        for (int n = 0; n < 3000 && maintOpActive_n !== v; n++)
            @(posedge clk) #1;
        chk(maintOpActive_n, v);
    endtask
    task automatic req(input logic isFlush);
        @(posedge clk);
        flushReq_n <= !isFlush;
        syncReq_n <= isFlush;
        repeat (3) @(posedge clk);
        flushReq_n <= 1'h1;
        syncReq_n <= 1'h1;
    endtask
    task automatic ahb(input logic wr, input logic [31:0] a, d);
        @(posedge clk);
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge clk); while (hreadyout !== 1'h1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'h1);
        rd = hrdata;
        chk(hresp, 1'h0);
    endtask
    task automatic doReset(input logic fl, st);
        @(posedge clk);
        rst_b <= 1'h0;
        floatSelect_n <= fl;
        selftestSelect_n <= st;
        flushReq_n <= 1'h1;
        repeat (16) @(posedge clk);
        #1 chk({maintOpActive_n, maintOpActiveOe}, 2'h2);
        @(posedge clk);
        rst_b <= 1'h1;
    endtask
    // ---------
    // scenarios
    // ---------
    task automatic t_init();
        doReset(1'h1, 1'h1);
        waitAct(1'h0);
        ahb(1'h0, 32'h4, 32'h0);
        chk(rd, 32'h3);
        chk(bistRun, 1'h0);
        waitAct(1'h1);
        ahb(1'h0, 32'h4, 32'h0);
        chk(rd, 32'h40);
        ahb(1'h0, 32'h0, 32'h0);
        chk(rd, 32'hFF);
        ahb(1'h1, 32'h0, 32'hFFFFFF03);
        ahb(1'h0, 32'h0, 32'h0);
        chk(rd, 32'h3);
        ahb(1'h0, 32'h8, 32'h0);
        chk(rd, 32'h0);
        floatSelect_n <= 1'h0;
        @(posedge clk) #1 chk(membusAddrLatchEn, 1'h0);
        floatSelect_n <= 1'h1;
        @(posedge clk) #1 chk(membusAddrLatchEn, 1'h1);
        chk(maintOpActiveOe, 1'h1);
        // an idle sequencer lets a normal strobe through
        normAddrStrobe <= 1'h1;
        @(posedge clk) #1 chk(cacheAddrStrobe_n, 1'h0);
        normAddrStrobe <= 1'h0;
    endtask
    task automatic t_flush();
        int s0;
        @(posedge clk);
        lat <= 4'h6;
        lineModified <= 1'h1;
        busIdle <= 1'h0;
        req(1'h1);
        repeat (8) @(posedge clk);
        #1 chk(maintOpActive_n, 1'h1);
        chk(burstReady_n, 1'h1);
        @(posedge clk);
        busIdle <= 1'h1;
        waitAct(1'h0);
        s0 = strobes;
        chk(cacheHoldOut, 1'h1);
        // normal strobes must stay out of the flush
        normAddrStrobe <= 1'h1;
        ahb(1'h0, 32'h4, 32'h0);
        chk(rd, 32'h45);
        chk(burstReady_n, 1'h0);
        req(1'h1);
        req(1'h0);
        waitAct(1'h1);
        chk(strobes - s0, 32'h4);
        chk(lineIndex, 32'h3);
        normAddrStrobe <= 1'h0;
        repeat (30) @(posedge clk);
        #1 chk(maintOpActive_n, 1'h1);
        chk(syncRun, 1'h0);
    endtask
    task automatic t_sync();
        req(1'h0);
        waitAct(1'h0);
        @(posedge clk) #1 chk(syncRun, 1'h1);
        ahb(1'h0, 32'h4, 32'h0);
        chk(rd, 32'h47);
        req(1'h0);
        syncDone <= 1'h1;
        @(posedge clk);
        syncDone <= 1'h0;
        waitAct(1'h1);
        repeat (12) @(posedge clk);
        #1 chk(syncRun, 1'h0);
    endtask
    task automatic t_preempt();
        int g0;
        lineModified <= 1'h0;
        req(1'h0);
        waitAct(1'h0);
        g0 = gaps;
        watchGap = 1'h1;
        req(1'h1);
        repeat (6) @(posedge clk);
        #1 chk(cacheHoldOut, 1'h1);
        chk(syncRun, 1'h0);
        waitAct(1'h1);
        watchGap = 1'h0;
        chk(gaps - g0, 32'h0);
        repeat (12) @(posedge clk);
        #1 chk(syncRun, 1'h0);
    endtask
    task automatic t_bist();
        @(posedge clk);
        lat <= 4'h0;
        lineModified <= 1'h1;
        req(1'h1);
        waitAct(1'h0);
        doReset(1'h1, 1'h0);
        waitAct(1'h0);
        @(posedge clk) #1 chk(bistRun, 1'h1);
        ahb(1'h0, 32'h4, 32'h0);
        chk(rd, 32'h0B);
        bistFail <= 1'h1;
        bistDone <= 1'h1;
        @(posedge clk);
        bistDone <= 1'h0;
        repeat (2) @(posedge clk);
        #1 chk(cacheHoldOut, 1'h1);
        waitAct(1'h1);
        ahb(1'h0, 32'h4, 32'h0);
        chk(rd, 32'h68);
    endtask
    task automatic t_float();
        doReset(1'h0, 1'h0);
        repeat (4) @(posedge clk);
        #1 chk({maintOpActiveOe, cacheHoldOe, cacheAddrStrobeOe}, 3'h0);
        waitAct(1'h1);
        req(1'h1);
        repeat (20) @(posedge clk);
        #1 chk({maintOpActiveOe, cacheHoldOe, cacheAddrStrobeOe}, 3'h0);
    endtask
    initial begin
        #400000;
        err_total++;
        give_verdict();
    end
    initial begin
        {rst_b, flushReq_n, syncReq_n, floatSelect_n} = 4'h7;
        {selftestSelect_n, busIdle, lineModified, normAddrStrobe} = 4'hC;
        {syncDone, bistDone, bistFail, hwrite, watchGap} = 5'h0;
        htrans = 2'h0;
        lat = 4'h0;
        haddr = 32'h0;
        hwdata = 32'h0;
        t_init();
        t_flush();
        t_sync();
        t_preempt();
        t_bist();
        t_float();
        give_verdict();
    end
endmodule // tb_top
`default_nettype wire
